// File: design/etc_consts.vh
// constants for the exposure trigger control block
// assumes one 250 MHz clock; all durations are counted in clock cycles
// What this block does
// - programmable mode starts exposure on trigger rise
// - programmable mode ends exposure after timed duration
// - trigger during frame defers to line_valid fall
// - trigger outside frame starts after fixed delay
// - new exposure time taken safely while running
// - default trigger line selected after reset
// - software command may also start exposure
// - readout delay follows exposure end in programmable mode only; pulse-width mode starts readout directly
// - durations counted in whole clock periods
// - values return to defaults without saved config
// - settings take effect the cycle after loading; exposure time latched at start
// - pulse-width mode exposes while trigger high
// - line and frame valid framing during readout
`ifndef ETC_CONSTS_VH
`define ETC_CONSTS_VH
`define ETC_CLK_PERIOD_PS      32'd4000
`define ETC_START_DELAY_NS     32'd60
`define ETC_START_DELAY_CYC    ((`ETC_START_DELAY_NS * 32'd1000 + `ETC_CLK_PERIOD_PS - 32'd1) / `ETC_CLK_PERIOD_PS)
`define ETC_MIN_PULSE_NS       32'd100
`define ETC_MIN_PULSE_CYC      ((`ETC_MIN_PULSE_NS * 32'd1000 + `ETC_CLK_PERIOD_PS - 32'd1) / `ETC_CLK_PERIOD_PS)
`define ETC_EXP_RST            32'd250000
`define ETC_RD_DELAY_RST       32'd0
`define ETC_TRIG_SEL_RST       2'h1
`define ETC_MODE_PROG          1'b0
`define ETC_MODE_PULSE         1'b1
`define ETC_MODE_RST           1'b0
`define ETC_LINES_RST          16'h0010
`define ETC_LINE_LEN_RST       16'h0040
`define ETC_LINE_GAP_RST       16'h0010
`endif

// File: design/etc_exposure_trigger_control.v
// exposure trigger sequencing: trigger, exposure timing, readout delay, frame/line framing
// assumes trigger pins asynchronous; settings are quasi-static ports on ref_clk_i
`include "etc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module etc_exposure_trigger_control (
   input  wire        ref_clk_i,
   input  wire        rst_b_i,
   input  wire [3:0]  trig_pins_i,
   input  wire [1:0]  trig_sel_i,
   input  wire        trig_sel_load_i,
   input  wire        pulse_mode_i,
   input  wire        mode_load_i,
   input  wire [31:0] exposure_cyc_i,
   input  wire        exposure_load_i,
   input  wire [31:0] readout_delay_cyc_i,
   input  wire        readout_delay_load_i,
   input  wire        sw_trigger_i,
   input  wire [15:0] lines_per_frame_i,
   input  wire [15:0] line_len_cyc_i,
   input  wire [15:0] line_gap_cyc_i,
   input  wire        framing_load_i,
   output reg         exposing_o,
   output reg         readout_wait_o,
   output reg         frame_valid_o,
   output reg         line_valid_o,
   output reg         trig_ignored_o
);
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_SYNC  = 3'h1;
   localparam [2:0] ST_DLY   = 3'h2;
   localparam [2:0] ST_EXP   = 3'h3;
   localparam [2:0] ST_PEXP  = 3'h4;
   localparam [2:0] ST_RDLY  = 3'h5;

   reg  [3:0]  pin_s1_r;
   reg  [3:0]  pin_s2_r;
   reg         trig_d_r;
   reg  [1:0]  sel_r;
   reg         mode_r;
   reg  [31:0] exp_r;
   reg  [31:0] rd_dly_r;
   reg  [15:0] lines_r;
   reg  [15:0] llen_r;
   reg  [15:0] lgap_r;
   reg  [2:0]  st_r;
   reg  [31:0] cnt_r;
   reg  [31:0] exp_lat_r;
   reg         lv_d_r;
   reg         rd_start_r;
   reg  [15:0] line_cnt_r;
   reg  [15:0] pix_cnt_r;
   reg         in_gap_r;

   wire trig_lvl  = pin_s2_r[sel_r];
   wire trig_rise = trig_lvl & ~trig_d_r;
   wire trig_fall = ~trig_lvl & trig_d_r;
   wire lv_fall   = lv_d_r & ~line_valid_o;
   wire start_req = trig_rise | sw_trigger_i;

   // settings: defaults at reset, new value used from the next cycle
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         sel_r    <= `ETC_TRIG_SEL_RST;
         mode_r   <= `ETC_MODE_RST;
         exp_r    <= `ETC_EXP_RST;
         rd_dly_r <= `ETC_RD_DELAY_RST;
         lines_r  <= `ETC_LINES_RST;
         llen_r   <= `ETC_LINE_LEN_RST;
         lgap_r   <= `ETC_LINE_GAP_RST;
      end else begin
         if (trig_sel_load_i) sel_r <= trig_sel_i;
         if (mode_load_i) mode_r <= pulse_mode_i;
         if (exposure_load_i) exp_r <= exposure_cyc_i;
         if (readout_delay_load_i) rd_dly_r <= readout_delay_cyc_i;
         if (framing_load_i) begin
            lines_r <= lines_per_frame_i;
            llen_r  <= line_len_cyc_i;
            lgap_r  <= line_gap_cyc_i;
         end
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
         trig_d_r <= 1'b0;
         lv_d_r   <= 1'b0;
      end else begin
         pin_s1_r <= trig_pins_i;
         pin_s2_r <= pin_s1_r;
         trig_d_r <= trig_lvl;
         lv_d_r   <= line_valid_o;
      end
   end

   // exposure sequencer
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_r           <= ST_IDLE;
         cnt_r          <= 32'h0;
         exp_lat_r      <= `ETC_EXP_RST;
         exposing_o     <= 1'b0;
         readout_wait_o <= 1'b0;
         rd_start_r     <= 1'b0;
         trig_ignored_o <= 1'b0;
      end else begin
         rd_start_r     <= 1'b0;
         trig_ignored_o <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (start_req) begin
                  exp_lat_r <= exp_r;
                  if (frame_valid_o) begin
                     st_r <= ST_SYNC;
                  end else begin
                     st_r  <= ST_DLY;
                     cnt_r <= `ETC_START_DELAY_CYC;
                  end
               end
            end
            ST_SYNC: begin
               trig_ignored_o <= start_req;
               if (lv_fall || !frame_valid_o) begin
                  st_r       <= mode_r ? ST_PEXP : ST_EXP;
                  cnt_r      <= exp_lat_r;
                  exposing_o <= 1'b1;
               end
            end
            ST_DLY: begin
               trig_ignored_o <= start_req;
               if (cnt_r <= 32'h1) begin
                  st_r       <= mode_r ? ST_PEXP : ST_EXP;
                  cnt_r      <= exp_lat_r;
                  exposing_o <= 1'b1;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            ST_EXP: begin
               trig_ignored_o <= start_req;
               if (cnt_r <= 32'h1) begin
                  exposing_o     <= 1'b0;
                  st_r           <= ST_RDLY;
                  cnt_r          <= rd_dly_r;
                  readout_wait_o <= 1'b1;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            ST_PEXP: begin
               trig_ignored_o <= trig_rise;
               // falls during frame_valid are not expected
               if (trig_fall || sw_trigger_i) begin
                  exposing_o <= 1'b0;
                  st_r       <= ST_IDLE;
                  rd_start_r <= 1'b1;
               end
            end
            ST_RDLY: begin
               trig_ignored_o <= start_req;
               if (cnt_r == 32'h0) begin
                  readout_wait_o <= 1'b0;
                  rd_start_r     <= 1'b1;
                  st_r           <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            default: begin
               st_r       <= ST_IDLE;
               exposing_o <= 1'b0;
            end
         endcase
      end
   end

   // readout framing: frame_valid over all lines, line_valid per line
   always @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         frame_valid_o <= 1'b0;
         line_valid_o  <= 1'b0;
         line_cnt_r    <= 16'h0;
         pix_cnt_r     <= 16'h0;
         in_gap_r      <= 1'b0;
      end else if (!frame_valid_o) begin
         if (rd_start_r && lines_r != 16'h0 && llen_r != 16'h0) begin
            frame_valid_o <= 1'b1;
            line_valid_o  <= 1'b1;
            line_cnt_r    <= lines_r;
            pix_cnt_r     <= llen_r;
            in_gap_r      <= 1'b0;
         end
      end else if (!in_gap_r) begin
         if (pix_cnt_r <= 16'h1) begin
            line_valid_o <= 1'b0;
            if (line_cnt_r <= 16'h1) begin
               frame_valid_o <= 1'b0;
            end else begin
               in_gap_r   <= 1'b1;
               pix_cnt_r  <= lgap_r;
               line_cnt_r <= line_cnt_r - 16'h1;
            end
         end else begin
            pix_cnt_r <= pix_cnt_r - 16'h1;
         end
      end else begin
         if (pix_cnt_r <= 16'h1) begin
            in_gap_r     <= 1'b0;
            line_valid_o <= 1'b1;
            pix_cnt_r    <= llen_r;
         end else begin
            pix_cnt_r <= pix_cnt_r - 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/etc_chk_sva.sv
// checker on the exposure trigger control ports
// assumes bind into the design top; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module etc_chk (
   input wire logic       ref_clk_i,
   input wire logic       rst_b_i,
   input wire logic [3:0] trig_pins_i,
   input wire logic       pulse_mode_i,
   input wire logic       sw_trigger_i,
   input wire logic       exposing_o,
   input wire logic       readout_wait_o,
   input wire logic       frame_valid_o,
   input wire logic       line_valid_o,
   input wire logic       trig_ignored_o
);
   logic [4:0] quiet_r;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // cycles with no start request and nothing running
   always_ff @(posedge ref_clk_i)
      if (!rst_b_i || sw_trigger_i || trig_pins_i != 4'h0 || exposing_o || readout_wait_o || frame_valid_o)
         quiet_r <= 5'h00;
      else if (quiet_r != 5'h1F)
         quiet_r <= quiet_r + 5'h01;
   sequence s_idle_start;
      quiet_r == 5'h1F && sw_trigger_i;
   endsequence
   sequence s_fixed_delay;
      !exposing_o [*8] ##1 !exposing_o [*7] ##[1:2] exposing_o;
   endsequence
   a_start_delay: assert property (s_idle_start |=> s_fixed_delay) else $error("start delay");
   a_line_framed: assert property (line_valid_o |-> frame_valid_o) else $error("line outside frame");
   a_frame_opens: assert property ($rose(frame_valid_o) |-> line_valid_o) else $error("frame no line");
   a_wait_follows: assert property ($rose(readout_wait_o) |-> $past(exposing_o) && !exposing_o)
      else $error("wait not after exposure");
   a_wait_to_frame: assert property ($fell(readout_wait_o) |-> ##[0:2] frame_valid_o)
      else $error("no frame after wait");
   a_busy_flag: assert property (!pulse_mode_i && sw_trigger_i && exposing_o |=> trig_ignored_o)
      else $error("busy start not flagged");
   a_defer_line: assert property ($rose(exposing_o) && frame_valid_o |->
      $past(line_valid_o, 2) && !$past(line_valid_o, 1)) else $error("start not on line fall");
   a_reset_clear: assert property (disable iff (1'b0) !rst_b_i |=>
      !(exposing_o || readout_wait_o || frame_valid_o || line_valid_o || trig_ignored_o)) else $error("reset");
endmodule
bind etc_exposure_trigger_control etc_chk etc_chk_i (.ref_clk_i, .rst_b_i, .trig_pins_i, .pulse_mode_i,
   .sw_trigger_i, .exposing_o, .readout_wait_o, .frame_valid_o, .line_valid_o, .trig_ignored_o);
`default_nettype wire

// File: testbench/etc_trig_src.sv
// trigger source model driving the four trigger pins
// assumes frame_valid_i from the design on the same clock
`include "etc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module etc_trig_src (
   input  wire logic       clk_i,
   input  wire logic       frame_valid_i,
   output var  logic [3:0] trig_pins_o
);
   initial trig_pins_o = 4'h0;
   // pw: hold the level until the running frame is over
   task automatic pulse(input int idx, input int width, input logic pw);
      @(posedge clk_i);
      #1 trig_pins_o[idx] = 1'b1;
      repeat ((width < `ETC_MIN_PULSE_CYC) ? `ETC_MIN_PULSE_CYC : width) @(posedge clk_i);
      while (pw && frame_valid_i) @(posedge clk_i);
      #1 trig_pins_o[idx] = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: testbench/tb_etc_exposure_trigger_control.sv
// self-checking bench for exposure trigger control
// assumes the trigger source model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_etc_exposure_trigger_control;
   logic        clk, rst_b, mode, expo, rwait, fv, lv, ign;
   logic [5:0]  ld;
   logic [1:0]  sel;
   logic [31:0] n, exp_v, rd_v, exp_q[$], wait_q[$];
   wire  [3:0]  pins;
   int          fail_count, cmp_count, elen, wlen, i, seed;
   etc_exposure_trigger_control etc_exposure_trigger_control_i (.ref_clk_i(clk), .rst_b_i(rst_b),
      .trig_pins_i(pins), .trig_sel_i(sel), .trig_sel_load_i(ld[2]), .pulse_mode_i(mode), .mode_load_i(ld[3]),
      .exposure_cyc_i(exp_v), .exposure_load_i(ld[0]), .readout_delay_cyc_i(rd_v), .readout_delay_load_i(ld[1]),
      .sw_trigger_i(ld[5]), .lines_per_frame_i(16'h0004), .line_len_cyc_i(16'h0014), .line_gap_cyc_i(16'h0006),
      .framing_load_i(ld[4]), .exposing_o(expo), .readout_wait_o(rwait), .frame_valid_o(fv), .line_valid_o(lv),
      .trig_ignored_o(ign));
   etc_trig_src etc_trig_src_i (.clk_i(clk), .frame_valid_i(fv), .trig_pins_o(pins));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic pulse_ld(input int b);
      ld[b] = 1'b1;
      step(1);
      ld[b] = 1'b0;
      step(1);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         fail_count++;
         $display("wrong value at %0t: saw %0h want %0h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic settle(input int c);
      step(20);
      for (i = 0; i < 3000 && (fv !== 1'b0 || expo !== 1'b0 || rwait !== 1'b0); i++) step(1);
      step(40);
      $display("test %0d done", c);
   endtask
   // measures each programmable-mode exposure and each readout wait run
   always @(posedge clk) begin
      if (expo !== 1'b1 && elen != 0 && mode === 1'b0)
         check(elen, exp_q.pop_front());
      if (rwait !== 1'b1 && wlen != 0)
         check(wlen, wait_q.pop_front());
      elen = (expo === 1'b1) ? elen + 1 : 0;
      wlen = (rwait === 1'b1) ? wlen + 1 : 0;
   end
   initial begin
      seed = 32'h773A;
      {rst_b, mode, ld, sel, exp_v, rd_v} = '0;
      step(8);
      rst_b = 1'b1;
      pulse_ld(4);
      n = 20 + ($random(seed) & 31);
      rd_v = $random(seed) & 15;
      exp_v = n;
      exp_q = '{n, n, n, n + 7, n + 7};
      wait_q = '{1, rd_v + 1, rd_v + 1, rd_v + 1, rd_v + 1};
      pulse_ld(0);
      etc_trig_src_i.pulse(1, 30, 1'b0);
      settle(1);
      sel = 2'h2;
      pulse_ld(2);
      pulse_ld(1);
      etc_trig_src_i.pulse(2, 30, 1'b0);
      settle(2);
      pulse_ld(5);
      step(25);
      exp_v = n + 7;
      pulse_ld(0);
      pulse_ld(5);
      settle(3);
      pulse_ld(5);
      for (i = 0; i < 500 && fv !== 1'b1; i++) step(1);
      pulse_ld(5);
      settle(4);
      mode = 1'b1;
      pulse_ld(3);
      fork
         etc_trig_src_i.pulse(2, 60, 1'b1);
      join_none
      step(45);
      check(expo, 1'b1);
      settle(5);
      check(exp_q.size() + wait_q.size(), 0);
      tally_and_finish;
   end
   initial begin
      step(20000);
      fail_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
